// File: ac97_evt_params.svh
// Constants for the audio link event and interrupt block
// Functional notes
// - DMA enable off masks DMA flags
// - Codec mode bits enable codec flags
// - Status read clears wake and frame flags
// - Frame start since last read sets flag
// - Rising edge on data-in sets wake
// - Codec event equals status AND mode nonzero
// - Slot A event equals status AND mode
// - Slot B event equals status AND mode
// - Enable-set write ones enable interrupts
// - Enable-clear write ones disable interrupts
// - Enable view reads current enables
`ifndef AC97_EVT_PARAMS_SVH
`define AC97_EVT_PARAMS_SVH
`define OFS_SLOT_A_STATUS 8'h00
`define OFS_SLOT_A_MODE 8'h04
`define OFS_SLOT_B_STATUS 8'h08
`define OFS_SLOT_B_MODE 8'h0C
`define OFS_CODEC_STATUS 8'h10
`define OFS_CODEC_MODE 8'h14
`define OFS_CTRL_STATUS 8'h18
`define OFS_IRQ_SET 8'h1C
`define OFS_IRQ_CLEAR 8'h20
`define OFS_IRQ_VIEW 8'h24
`define SLOT_A_MODE_MASK 32'h0060_CC37
`define SLOT_B_MODE_MASK 32'h0020_0037
`define SLOT_FLAG_MASK 32'h0000_0037
`define DMA_FLAG_MASK 32'h0000_CC00
`define DMA_EN_BIT 22
`define CTRL_MASK 5'h1F
`define BIT_SOF 0
`define BIT_WAKE 1
`define BIT_CODEC 2
`define BIT_SLOT_A 3
`define BIT_SLOT_B 4
`define MODE_RESET 32'h0000_0000
`endif

// File: ac97_evt_pkg.sv
// Types for the audio link event and interrupt block
`default_nettype none
package ac97_evt_pkg;
  typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} bus_phase_t;
endpackage
`default_nettype wire

// File: ac97_wake_edge.sv
// Rising edge detector for the codec data-in wake line
`timescale 1ns/100ps
`default_nettype none
module ac97_wake_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic din,
  output logic rise
);
  logic din_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      din_q <= 1'b0;
    end else if (ce) begin
      din_q <= din;
    end
  end

  assign rise = ce & din & ~din_q;
endmodule // ac97_wake_edge
`default_nettype wire

// File: ac97_event_irq.sv
// Event gathering, interrupt enables and AHB-Lite slave
`include "ac97_evt_params.svh"
`timescale 1ns/100ps
`default_nettype none
module ac97_event_irq (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [31:0] SLOT_A_FLAGS,
  input wire logic [31:0] SLOT_B_FLAGS,
  input wire logic [31:0] CODEC_FLAGS,
  input wire logic FRAME_START,
  input wire logic SDATA_IN,
  output logic SLOT_A_DMA_ROUTE,
  output logic IRQ
);
  ac97_evt_pkg::bus_phase_t phase_q;
  logic [7:0] addr_q;
  logic [31:0] slot_a_mode_q;
  logic [31:0] slot_b_mode_q;
  logic [31:0] codec_mode_q;
  logic [4:0] irq_en_q;
  logic sof_q;
  logic wake_q;
  logic wake_rise;
  logic [31:0] slot_a_stat;
  logic [31:0] slot_b_stat;
  logic [31:0] codec_stat;
  logic [4:0] status_d;
  logic take;
  logic wr_now;
  logic rd_status;
  logic [31:0] rdata_d;

  function automatic logic any_hit(input logic [31:0] s,
                                   input logic [31:0] m);
    any_hit = |(s & m);
  endfunction

  // Write data phase aimed at one register offset
  function automatic logic wr_to(input logic [7:0] ofs);
    wr_to = wr_now && (addr_q == ofs);
  endfunction

  ac97_wake_edge u_wake (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .din(SDATA_IN),
    .rise(wake_rise)
  );

  // DMA flags only visible when slot A is routed through DMA
  assign slot_a_stat = SLOT_A_FLAGS & (slot_a_mode_q[`DMA_EN_BIT] ?
    (`SLOT_FLAG_MASK | `DMA_FLAG_MASK) : `SLOT_FLAG_MASK);
  assign slot_b_stat = SLOT_B_FLAGS & `SLOT_FLAG_MASK;
  assign codec_stat = CODEC_FLAGS & `SLOT_FLAG_MASK;

  assign take = HSEL & HREADY & HTRANS[1];
  assign wr_now = CE & (phase_q == ac97_evt_pkg::BUS_WRITE);
  assign rd_status = CE & (phase_q == ac97_evt_pkg::BUS_READ) &
    (addr_q == `OFS_CTRL_STATUS);

  always_ff @(posedge CLK) begin
    if (RST) begin
      phase_q <= ac97_evt_pkg::BUS_IDLE;
      addr_q <= 8'h00;
    end else if (CE) begin
      if (take) begin
        phase_q <= HWRITE ? ac97_evt_pkg::BUS_WRITE
                          : ac97_evt_pkg::BUS_READ;
        addr_q <= HADDR[7:0];
      end else begin
        phase_q <= ac97_evt_pkg::BUS_IDLE;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      slot_a_mode_q <= `MODE_RESET;
      slot_b_mode_q <= `MODE_RESET;
      codec_mode_q <= `MODE_RESET;
    end else if (wr_now) begin
      case (addr_q)
        `OFS_SLOT_A_MODE: slot_a_mode_q <= HWDATA & `SLOT_A_MODE_MASK;
        `OFS_SLOT_B_MODE: slot_b_mode_q <= HWDATA & `SLOT_B_MODE_MASK;
        `OFS_CODEC_MODE: codec_mode_q <= HWDATA & `SLOT_FLAG_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_en_q <= 5'h00;
    end else if (wr_to(`OFS_IRQ_SET)) begin
      irq_en_q <= irq_en_q | HWDATA[4:0];
    end else if (wr_to(`OFS_IRQ_CLEAR)) begin
      irq_en_q <= irq_en_q & ~HWDATA[4:0];
    end
  end

  // A new event in the read cycle survives: set beats clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      sof_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (CE) begin
      sof_q <= FRAME_START | (sof_q & ~rd_status);
      wake_q <= wake_rise | (wake_q & ~rd_status);
    end
  end

  always_comb begin
    status_d = 5'h00;
    status_d[`BIT_SOF] = sof_q;
    status_d[`BIT_WAKE] = wake_q;
    status_d[`BIT_CODEC] = any_hit(codec_stat, codec_mode_q);
    status_d[`BIT_SLOT_A] = any_hit(slot_a_stat, slot_a_mode_q);
    status_d[`BIT_SLOT_B] = any_hit(slot_b_stat, slot_b_mode_q);
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (addr_q)
      `OFS_SLOT_A_STATUS: rdata_d = slot_a_stat;
      `OFS_SLOT_A_MODE: rdata_d = slot_a_mode_q;
      `OFS_SLOT_B_STATUS: rdata_d = slot_b_stat;
      `OFS_SLOT_B_MODE: rdata_d = slot_b_mode_q;
      `OFS_CODEC_STATUS: rdata_d = codec_stat;
      `OFS_CODEC_MODE: rdata_d = codec_mode_q;
      `OFS_CTRL_STATUS: rdata_d = {27'h0, status_d};
      `OFS_IRQ_VIEW: rdata_d = {27'h0, irq_en_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Zeroed at each read address phase, so the stall cycle never
  // shows the word of an earlier read
  always_ff @(posedge CLK) begin
    if (RST) begin
      HRDATA <= 32'h0000_0000;
    end else if (CE) begin
      if (phase_q == ac97_evt_pkg::BUS_READ) begin
        HRDATA <= rdata_d;
      end else if (take && !HWRITE) begin
        HRDATA <= 32'h0000_0000;
      end
    end
  end

  // Registered: one cycle of lag buys a pin free of decode glitches
  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= |(status_d & irq_en_q);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      SLOT_A_DMA_ROUTE <= 1'b0;
    end else if (CE) begin
      SLOT_A_DMA_ROUTE <= slot_a_mode_q[`DMA_EN_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else if (CE) begin
      HREADYOUT <= ~(take & ~HWRITE);
      HRESP <= 1'b0;
    end
  end

  irq_level_a: assert property (@(posedge CLK) disable iff (RST)
    CE |=> (IRQ == $past(|(status_d & irq_en_q))))
    else $error("interrupt does not follow enabled status");
  sof_clear_a: assert property (@(posedge CLK) disable iff (RST)
    (rd_status && !FRAME_START) |=> !sof_q)
    else $error("frame flag not cleared by status read");
  sof_set_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && FRAME_START) |=> sof_q)
    else $error("frame flag not set");
  wake_set_a: assert property (@(posedge CLK) disable iff (RST)
    wake_rise |=> wake_q)
    else $error("wake flag not set on rising edge");
  set_en_a: assert property (@(posedge CLK) disable iff (RST)
    (wr_now && addr_q == `OFS_IRQ_SET) |=>
      (irq_en_q == ($past(irq_en_q) | $past(HWDATA[4:0]))))
    else $error("enable set wrong");
  clr_en_a: assert property (@(posedge CLK) disable iff (RST)
    (wr_now && addr_q == `OFS_IRQ_CLEAR) |=>
      (irq_en_q == ($past(irq_en_q) & ~$past(HWDATA[4:0]))))
    else $error("enable clear wrong");
  codec_evt_a: assert property (@(posedge CLK) disable iff (RST)
    status_d[`BIT_CODEC] == (|(CODEC_FLAGS[5:0] & codec_mode_q[5:0])))
    else $error("codec event mismatch");
  dma_mask_a: assert property (@(posedge CLK) disable iff (RST)
    !slot_a_mode_q[`DMA_EN_BIT] |-> (slot_a_stat[15:8] == 8'h00))
    else $error("DMA flags seen with routing off");
  view_read_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && phase_q == ac97_evt_pkg::BUS_READ && addr_q == `OFS_IRQ_VIEW)
      |=> (HRDATA[4:0] == $past(irq_en_q)))
    else $error("enable view read wrong");

  // Bus handshake and read data
  hresp_okay_a: assert property (@(posedge CLK) disable iff (RST)
    HRESP == 1'b0)
    else $error("slave response is not OKAY");
  read_stall_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && take && !HWRITE) |=> !HREADYOUT)
    else $error("read data phase not stalled");
  stall_once_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && !HREADYOUT && !take) |=> HREADYOUT)
    else $error("stall longer than one cycle");
  write_ready_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && take && HWRITE) |=> HREADYOUT)
    else $error("write data phase stalled");
  phase_idle_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && !take) |=> (phase_q == ac97_evt_pkg::BUS_IDLE))
    else $error("data phase without address phase");
  read_data_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && phase_q == ac97_evt_pkg::BUS_READ)
      |=> (HRDATA == $past(rdata_d)))
    else $error("read data not presented");
  hold_data_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && phase_q != ac97_evt_pkg::BUS_READ && !(take && !HWRITE))
      |=> $stable(HRDATA))
    else $error("read data changed outside a read");
  unmapped_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && phase_q == ac97_evt_pkg::BUS_READ && addr_q > `OFS_IRQ_VIEW)
      |=> (HRDATA == 32'h0000_0000))
    else $error("unmapped read not zero");
  view_bits_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && phase_q == ac97_evt_pkg::BUS_READ && addr_q >= `OFS_CTRL_STATUS)
      |=> (HRDATA[31:5] == 27'h0))
    else $error("unused upper bits read nonzero");
  status_read_a: assert property (@(posedge CLK) disable iff (RST)
    rd_status |=> (HRDATA[4:0] == $past(status_d)))
    else $error("status read returns wrong flags");

  // Mode and enable registers
  slot_a_wr_a: assert property (@(posedge CLK) disable iff (RST)
    (wr_now && addr_q == `OFS_SLOT_A_MODE)
      |=> (slot_a_mode_q == ($past(HWDATA) & `SLOT_A_MODE_MASK)))
    else $error("slot A mode write wrong");
  slot_b_wr_a: assert property (@(posedge CLK) disable iff (RST)
    (wr_now && addr_q == `OFS_SLOT_B_MODE)
      |=> (slot_b_mode_q == ($past(HWDATA) & `SLOT_B_MODE_MASK)))
    else $error("slot B mode write wrong");
  codec_wr_a: assert property (@(posedge CLK) disable iff (RST)
    (wr_now && addr_q == `OFS_CODEC_MODE)
      |=> (codec_mode_q == ($past(HWDATA) & `SLOT_FLAG_MASK)))
    else $error("codec mode write wrong");
  mode_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !wr_now |=> ($stable(slot_a_mode_q) && $stable(slot_b_mode_q) &&
      $stable(codec_mode_q)))
    else $error("mode changed without a write");
  en_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !(wr_now && (addr_q == `OFS_IRQ_SET || addr_q == `OFS_IRQ_CLEAR))
      |=> $stable(irq_en_q))
    else $error("enables changed without a write");
  set_only_a: assert property (@(posedge CLK) disable iff (RST)
    (wr_now && addr_q == `OFS_IRQ_SET)
      |=> ((irq_en_q & $past(HWDATA[4:0])) == $past(HWDATA[4:0])))
    else $error("set write left an enable off");
  clr_only_a: assert property (@(posedge CLK) disable iff (RST)
    (wr_now && addr_q == `OFS_IRQ_CLEAR)
      |=> ((irq_en_q & $past(HWDATA[4:0])) == 5'h00))
    else $error("clear write left an enable on");
  route_copy_a: assert property (@(posedge CLK) disable iff (RST)
    CE |=> (SLOT_A_DMA_ROUTE == $past(slot_a_mode_q[`DMA_EN_BIT])))
    else $error("route output does not follow mode");
  dma_visible_a: assert property (@(posedge CLK) disable iff (RST)
    slot_a_mode_q[`DMA_EN_BIT]
      |-> (slot_a_stat[15:8] == (SLOT_A_FLAGS[15:8] & 8'hCC)))
    else $error("DMA flags hidden with routing on");

  // Sticky frame and wake flags
  sof_quiet_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && !FRAME_START && !sof_q) |=> !sof_q)
    else $error("frame flag set without frame start");
  sof_keep_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && sof_q && !rd_status) |=> sof_q)
    else $error("frame flag lost without read");
  wake_clear_a: assert property (@(posedge CLK) disable iff (RST)
    (rd_status && !wake_rise) |=> !wake_q)
    else $error("wake flag not cleared by status read");
  wake_keep_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && wake_q && !rd_status) |=> wake_q)
    else $error("wake flag lost without read");
  wake_quiet_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && !wake_rise && !wake_q) |=> !wake_q)
    else $error("wake flag set without edge");
  wake_edge_a: assert property (@(posedge CLK) disable iff (RST)
    (wake_rise && $past(CE)) |-> !$past(SDATA_IN))
    else $error("wake edge without low level before");

  // Channel events and interrupt pin
  slot_a_evt_a: assert property (@(posedge CLK) disable iff (RST)
    status_d[`BIT_SLOT_A] == ((|(SLOT_A_FLAGS[5:0] & slot_a_mode_q[5:0]))
      || (slot_a_mode_q[`DMA_EN_BIT] &&
      (|(SLOT_A_FLAGS[15:8] & slot_a_mode_q[15:8])))))
    else $error("slot A event mismatch");
  slot_b_evt_a: assert property (@(posedge CLK) disable iff (RST)
    status_d[`BIT_SLOT_B] ==
      (|(SLOT_B_FLAGS[5:0] & slot_b_mode_q[5:0])))
    else $error("slot B event mismatch");
  irq_rise_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && (|(status_d & irq_en_q))) |=> IRQ)
    else $error("interrupt missing for enabled flag");
  irq_drop_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && !(|(status_d & irq_en_q))) |=> !IRQ)
    else $error("interrupt without enabled flag");

  // Clock enable and reset
  freeze_state_a: assert property (@(posedge CLK) disable iff (RST)
    !CE |=> ($stable(irq_en_q) && $stable(sof_q) && $stable(wake_q) &&
      $stable(phase_q)))
    else $error("state moved with clock enable low");
  freeze_out_a: assert property (@(posedge CLK) disable iff (RST)
    !CE |=> ($stable(HRDATA) && $stable(IRQ) && $stable(HREADYOUT) &&
      $stable(SLOT_A_DMA_ROUTE)))
    else $error("outputs moved with clock enable low");
  rst_values_a: assert property (@(posedge CLK)
    RST |=> (HREADYOUT && !IRQ && (HRDATA == 32'h0000_0000) &&
      !SLOT_A_DMA_ROUTE && !HRESP))
    else $error("outputs not at reset values");
endmodule // ac97_event_irq
`default_nettype wire

// File: ac97_codec_model.sv
// Behavioural codec: frame-start pulses and wake edges on data-in
`timescale 1ns/100ps
`default_nettype none
module ac97_codec_model (
  input wire logic clk,
  input wire logic frame_go,
  input wire logic wake_go,
  output logic frame_start,
  output logic sdata_in
);
  // One pulse per request; data-in rises only when asked, to wake
  always_ff @(posedge clk) begin
    frame_start <= frame_go;
    sdata_in <= wake_go;
  end
endmodule // ac97_codec_model
`default_nettype wire

// File: ac97_event_interrupt_logic_tb_top.sv
// Self-checking bench for the event and interrupt block
`include "ac97_evt_params.svh"
`timescale 1ns/100ps
`default_nettype none
module ac97_event_interrupt_logic_tb_top;
  logic CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, IRQ, route, fgo, wgo, ce;
  logic FRAME_START, SDATA_IN;
  logic [1:0] HTRANS;
  logic [31:0] HADDR, HWDATA, HRDATA, af, bf, cf, r;
  int error_cnt = 0, check_count = 0, cyc = 0;
  logic [31:0] tbl [0:3][0:6] = '{
    '{32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8},
    '{32'h0, 32'h0, 32'h20, 32'h20, 32'h2, 32'h0, 32'h10},
    '{32'h400, 32'h400, 32'h0, 32'h0, 32'h10, 32'h10, 32'h4},
    '{32'h400, 32'h0040_0400, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8}};
  ac97_event_irq DUT (.CLK(CLK), .RST(RST), .CE(ce), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SLOT_A_FLAGS(af),
    .SLOT_B_FLAGS(bf), .CODEC_FLAGS(cf), .FRAME_START(FRAME_START),
    .SDATA_IN(SDATA_IN), .SLOT_A_DMA_ROUTE(route), .IRQ(IRQ));
  ac97_codec_model codec (.clk(CLK), .frame_go(fgo), .wake_go(wgo),
    .frame_start(FRAME_START), .sdata_in(SDATA_IN));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      results();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // Master holds each phase until ready is sampled high
  task automatic xfer(input logic w, input logic [31:0] a, d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    r = HRDATA;
  endtask
  initial begin
    {HSEL, HWRITE, fgo, wgo} = 4'h0;
    ce = 1'b1;
    HTRANS = 2'h0;
    {HADDR, HWDATA, af, bf, cf} = '0;
    RST = 1'b1;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk("irq", 32'h0, {31'h0, IRQ});
    for (int i = 0; i < 4; i++) begin
      af <= tbl[i][0];
      bf <= tbl[i][2];
      cf <= tbl[i][4];
      xfer(1'b1, `OFS_SLOT_A_MODE, tbl[i][1]);
      xfer(1'b1, `OFS_SLOT_B_MODE, tbl[i][3]);
      xfer(1'b1, `OFS_CODEC_MODE, tbl[i][5]);
      xfer(1'b0, `OFS_CTRL_STATUS, 32'h0);
      chk("events", tbl[i][6], r & 32'h1C);
      chk("route", {31'h0, tbl[i][1][22]}, {31'h0, route});
    end
    xfer(1'b0, `OFS_CODEC_MODE, 32'h0);
    chk("codec mode", 32'h0, r);
    {af, bf, cf} <= '0;
    xfer(1'b0, `OFS_IRQ_VIEW, 32'h0);
    chk("view rst", 32'h0, r);
    xfer(1'b1, `OFS_IRQ_SET, 32'h1D);
    xfer(1'b1, `OFS_IRQ_CLEAR, 32'h1C);
    xfer(1'b0, `OFS_IRQ_VIEW, 32'h0);
    chk("view", 32'h1, r);
    xfer(1'b0, 32'h0000_0040, 32'h0);
    chk("unmapped", 32'h0, r);
    chk("irq idle", 32'h0, {31'h0, IRQ});
    fgo <= 1'b1;
    wgo <= 1'b1;
    @(posedge CLK);
    fgo <= 1'b0;
    repeat (6) @(posedge CLK);
    chk("irq on", 32'h1, {31'h0, IRQ});
    xfer(1'b0, `OFS_CTRL_STATUS, 32'h0);
    chk("sof wake", 32'h3, r);
    xfer(1'b0, `OFS_CTRL_STATUS, 32'h0);
    chk("cleared", 32'h0, r);
    repeat (3) @(posedge CLK);
    chk("irq off", 32'h0, {31'h0, IRQ});
    chk("hresp", 32'h0, {31'h0, HRESP});
    // A write while the clock enable is low must be lost
    ce <= 1'b0;
    xfer(1'b1, `OFS_IRQ_SET, 32'h1E);
    ce <= 1'b1;
    xfer(1'b0, `OFS_IRQ_VIEW, 32'h0);
    chk("frozen", 32'h1, r);
    // Data-in lowered first, or reset would leave a false wake edge
    wgo <= 1'b0;
    xfer(1'b1, `OFS_IRQ_SET, 32'h1F);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk("irq rst", 32'h0, {31'h0, IRQ});
    chk("route rst", 32'h0, {31'h0, route});
    xfer(1'b0, `OFS_IRQ_VIEW, 32'h0);
    chk("view rst2", 32'h0, r);
    xfer(1'b0, `OFS_CTRL_STATUS, 32'h0);
    chk("status rst", 32'h0, r);
    results();
  end
endmodule // ac97_event_interrupt_logic_tb_top
`default_nettype wire
